// ---- src/ectq_defs.svh ----
/*
 * Constants of the event counter channel: register offsets, field positions, reset values and counter limits.
 * Assumes inclusion by bare name from every file that needs a number.
 */
`ifndef ECTQ_DEFS_SVH
`define ECTQ_DEFS_SVH

`define ECTQ_ADDR_W        8
`define ECTQ_OFF_TIMER     8'h00
`define ECTQ_OFF_MODE      8'h04
`define ECTQ_OFF_CTRL      8'h08
`define ECTQ_OFF_STATUS    8'h0C

`define ECTQ_CNT_W         16
`define ECTQ_CNT_MAX       16'hFFFF
`define ECTQ_CNT_MIN       16'h0000
`define ECTQ_CNT_ONE       16'h0001
`define ECTQ_RST_CNT       16'h0000
`define ECTQ_RST_BYTE      8'h00

`define ECTQ_MODE_OP_LSB   0
`define ECTQ_MODE_OP_MSB   1
`define ECTQ_MODE_PULSE    2
`define ECTQ_MODE_POL      3
`define ECTQ_MODE_DIRSRC   4
`define ECTQ_MODE_FREERUN  6
`define ECTQ_MODE_QUADX4   7
`define ECTQ_OP_EVENT      2'h1

`define ECTQ_CTRL_START    0
`define ECTQ_CTRL_UP       1
`define ECTQ_CTRL_TWOPH    2
`define ECTQ_CTRL_SRC_LSB  3
`define ECTQ_CTRL_SRC_MSB  4

`define ECTQ_RESP_OKAY     2'h0
`define ECTQ_RESP_SLVERR   2'h2

`endif

// ---- src/ectq_pkg.sv ----
/*
 * Types shared by the event counter channel: bus states, register selector and count source choice.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ectq_pkg;

   typedef enum logic [1:0] {ECTQ_SRC_PIN = 2'h0, ECTQ_SRC_COMPANION = 2'h1, ECTQ_SRC_SIBLING = 2'h2,
                             ECTQ_SRC_NONE = 2'h3} ectq_src_t;

   typedef enum logic [1:0] {ECTQ_REG_TIMER = 2'h0, ECTQ_REG_MODE = 2'h1, ECTQ_REG_CTRL = 2'h2,
                             ECTQ_REG_STATUS = 2'h3} ectq_reg_t;

   typedef enum logic {ECTQ_BUS_IDLE = 1'b0, ECTQ_BUS_ANSWER = 1'b1} ectq_bus_state_t;

endpackage

// ---- src/ectq_sync.sv ----
/*
 * Three-stage synchroniser for one pin; the output moves only when stages two and three agree.
 * Assumes an asynchronous pin input and the system clock domain.
 */
`timescale 1ns/100ps

module ectq_sync (
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   input  wire logic pin_async,
   output logic      pin_level
);

   logic s1_q;
   logic s2_q;
   logic s3_q;

   // The first stage feeds only the second, so metastability never reaches a decision.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s1_q      <= 1'b0;
         s2_q      <= 1'b0;
         s3_q      <= 1'b0;
         pin_level <= 1'b0;
      end else if (clk_en) begin
         s1_q <= pin_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            pin_level <= s3_q;
         end
      end
   end

endmodule // ectq_sync

// ---- src/ectq_top.sv ----
/*
 * One 16-bit event counter channel with single-phase and two-phase counting behind an AXI4-Lite slave.
 * Assumes a 25 MHz clk_sys, same-clock overflow pulses from the companion and sibling timers, and asynchronous pins.
 */
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
// Operation
// - A timer read while running returns the live counter value.
// - A read at the reload moment returns FFFF on underflow, 0000 on overflow.
// - After a stopped write, a read returns the written value until counting starts.
// - Single-phase source: pin edge, companion overflow or sibling channel overflow.
// - Single-phase direction comes from the software flag or the pin level.
// - Reload type loads the reload register on overflow or underflow, then continues.
// - Free-run type never reloads on wrap; the counter simply wraps.
// - Division ratio is 1/(FFFF-n+1) counting up and 1/(n+1) counting down.
// - Counting runs while the start flag is 1 and stops when it is 0.
// - Every overflow or underflow raises the interrupt request, in both phase modes.
// - A write while stopped updates the reload register and the counter.
// - A write while running updates only the reload register until the next reload.
// - With pulse output on, the output pin inverts on each overflow or underflow.
// - Single-phase output pin is general port, toggle output, or direction input.
// - Two-phase counting exists only on channels 2 to 4, both pins as inputs.
// - Two-phase direction comes solely from the phase relation of the pins.
// - Normal two-phase: with phase pin high, input rise counts up, fall counts down.
// - Times four: direction set by input edge with phase high; every edge counts.
// - Operation mode field value 01 selects event counter mode.
// - Polarity bit: 0 counts falling edges, 1 rising; only for pin counting.
// - Direction source bit: 0 software flag, 1 output pin level.
// - Operation type bit: 0 reload type, 1 free-run type.
`timescale 1ns/100ps
`include "ectq_defs.svh"

module ectq_top #(
   parameter int CHANNEL_INDEX = 3
) (
   input  wire logic                      clk_sys,
   input  wire logic                      sys_rst,
   input  wire logic                      clk_en,
   input  wire logic [`ECTQ_ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [`ECTQ_ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   input  wire logic                      event_input_pin,
   input  wire logic                      toggle_or_phase_pin_i,
   output logic                           toggle_or_phase_pin_o,
   output logic                           toggle_or_phase_pin_oe,
   input  wire logic                      companion_timer_overflow,
   input  wire logic                      sibling_channel_overflow,
   output logic                           irq_request
);
   import ectq_pkg::*;

   localparam logic TWO_PHASE_OK = (CHANNEL_INDEX >= 2) && (CHANNEL_INDEX <= 4);
   localparam logic X4_SELECTABLE = (CHANNEL_INDEX == 3);
   localparam logic X4_FIXED = (CHANNEL_INDEX == 4);

   // Register index from a byte address; also flags addresses outside the map.
   function automatic logic [2:0] ectq_decode(input logic [`ECTQ_ADDR_W-1:0] addr);
      logic [2:0] r;
      r = {1'b1, ECTQ_REG_TIMER};
      if (addr == `ECTQ_OFF_TIMER) begin
         r = {1'b0, ECTQ_REG_TIMER};
      end else if (addr == `ECTQ_OFF_MODE) begin
         r = {1'b0, ECTQ_REG_MODE};
      end else if (addr == `ECTQ_OFF_CTRL) begin
         r = {1'b0, ECTQ_REG_CTRL};
      end else if (addr == `ECTQ_OFF_STATUS) begin
         r = {1'b0, ECTQ_REG_STATUS};
      end
      return r;
   endfunction

   // Byte-lane merge of a 16-bit register with fresh write data.
   function automatic logic [15:0] ectq_merge16(input logic [15:0] old, input logic [31:0] data,
                                                input logic [3:0] strb);
      return {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
   endfunction

   // Counter state and software-visible control.
   logic [15:0]           cnt_q;
   logic [15:0]           reload_q;
   logic [7:0]            mode_q;
   logic [7:0]            ctrl_q;
   logic                  toggle_q;
   logic                  pin_oe_q;
   logic                  irq_q;
   logic                  in_prev_q;
   logic                  ph_prev_q;
   logic                  last_up_q;

   // Bus slave state.
   ectq_bus_state_t       ws_q;
   ectq_bus_state_t       rs_q;
   logic                  aw_have_q;
   logic                  w_have_q;
   logic [`ECTQ_ADDR_W-1:0] awaddr_q;
   logic [31:0]           wdata_q;
   logic [3:0]            wstrb_q;
   logic                  awready_q;
   logic                  wready_q;
   logic                  arready_q;
   logic                  bvalid_q;
   logic [1:0]            bresp_q;
   logic                  rvalid_q;
   logic [1:0]            rresp_q;
   logic [31:0]           rdata_q;

   logic                  in_lvl;
   logic                  ph_lvl;

   ectq_sync u_sync_in (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .clk_en    (clk_en),
      .pin_async (event_input_pin),
      .pin_level (in_lvl)
   );

   ectq_sync u_sync_ph (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .clk_en    (clk_en),
      .pin_async (toggle_or_phase_pin_i),
      .pin_level (ph_lvl)
   );

   // Mode and control fields.
   wire       event_mode = (mode_q[`ECTQ_MODE_OP_MSB:`ECTQ_MODE_OP_LSB] == `ECTQ_OP_EVENT);
   wire       running    = ctrl_q[`ECTQ_CTRL_START] & event_mode;
   wire       two_phase  = ctrl_q[`ECTQ_CTRL_TWOPH] & TWO_PHASE_OK;
   wire       free_run   = mode_q[`ECTQ_MODE_FREERUN];
   wire       pulse_en   = mode_q[`ECTQ_MODE_PULSE];
   wire       dir_pin    = mode_q[`ECTQ_MODE_DIRSRC];
   wire       quad_x4    = X4_FIXED | (X4_SELECTABLE & mode_q[`ECTQ_MODE_QUADX4]);
   ectq_src_t src_sel;
   assign src_sel = ectq_src_t'(ctrl_q[`ECTQ_CTRL_SRC_MSB:`ECTQ_CTRL_SRC_LSB]);

   // Edge detection on the synchronised pins.
   wire in_rise = in_lvl & ~in_prev_q;
   wire in_fall = ~in_lvl & in_prev_q;
   wire ph_edge = ph_lvl ^ ph_prev_q;
   wire in_edge = in_rise | in_fall;

   // Single-phase source and direction.
   wire pin_evt = mode_q[`ECTQ_MODE_POL] ? in_rise : in_fall;
   wire sp_evt  = (src_sel == ECTQ_SRC_PIN)       ? pin_evt :
                  (src_sel == ECTQ_SRC_COMPANION) ? companion_timer_overflow :
                  (src_sel == ECTQ_SRC_SIBLING)   ? sibling_channel_overflow : 1'b0;
   wire sp_up   = dir_pin ? ph_lvl : ctrl_q[`ECTQ_CTRL_UP];

   // Normal two-phase: only input edges count, and only while the phase pin is high.
   wire nq_evt = in_edge & ph_lvl;
   wire nq_up  = in_rise;
   // Times four: each single-pin edge counts; the direction follows the quadrature order,
   // so an input rise with phase high is up. Simultaneous edges are ambiguous and dropped.
   wire xq_evt = in_edge ^ ph_edge;
   wire xq_up  = in_prev_q ^ ph_lvl;

   wire step   = running & (two_phase ? (quad_x4 ? xq_evt : nq_evt) : sp_evt);
   wire up     = two_phase ? (quad_x4 ? xq_up : nq_up) : sp_up;

   wire ovf    = step & up & (cnt_q == `ECTQ_CNT_MAX);
   wire unf    = step & ~up & (cnt_q == `ECTQ_CNT_MIN);
   wire wrap   = ovf | unf;

   // Next counter value; the 16-bit arithmetic wraps by itself in free-run type.
   wire [15:0] cnt_inc  = cnt_q + `ECTQ_CNT_ONE;
   wire [15:0] cnt_dec  = cnt_q - `ECTQ_CNT_ONE;
   wire [15:0] cnt_step = (wrap & ~free_run) ? reload_q : (up ? cnt_inc : cnt_dec);

   // Bus decode.
   wire        aw_hs    = s_axi_awvalid & awready_q;
   wire        w_hs     = s_axi_wvalid & wready_q;
   wire        ar_hs    = s_axi_arvalid & arready_q;
   wire        do_wr    = (ws_q == ECTQ_BUS_IDLE) & aw_have_q & w_have_q;
   wire [2:0]  wr_dec   = ectq_decode(awaddr_q);
   wire [2:0]  rd_dec   = ectq_decode(s_axi_araddr);
   wire        wr_bad   = wr_dec[2];
   wire        rd_bad   = rd_dec[2];
   wire        wr_timer = do_wr & ~wr_bad & (ectq_reg_t'(wr_dec[1:0]) == ECTQ_REG_TIMER);
   wire        wr_mode  = do_wr & ~wr_bad & (ectq_reg_t'(wr_dec[1:0]) == ECTQ_REG_MODE);
   wire        wr_ctrl  = do_wr & ~wr_bad & (ectq_reg_t'(wr_dec[1:0]) == ECTQ_REG_CTRL);
   wire [15:0] wr_val16 = ectq_merge16(reload_q, wdata_q, wstrb_q);

   // A read taken in the very cycle of a wrap returns the wrap value, not the reload value.
   wire [15:0] live_cnt = ovf ? `ECTQ_CNT_MIN : (unf ? `ECTQ_CNT_MAX : cnt_q);
   wire [31:0] status_w = {28'h0000000, last_up_q, toggle_q, ph_lvl, in_lvl};
   wire [31:0] rd_word  = (ectq_reg_t'(rd_dec[1:0]) == ECTQ_REG_TIMER) ? {16'h0000, live_cnt} :
                          (ectq_reg_t'(rd_dec[1:0]) == ECTQ_REG_MODE)  ? {24'h000000, mode_q} :
                          (ectq_reg_t'(rd_dec[1:0]) == ECTQ_REG_CTRL)  ? {24'h000000, ctrl_q} : status_w;

   ectq_bus_state_t ws_d;
   ectq_bus_state_t rs_d;
   logic            aw_have_d;
   logic            w_have_d;
   assign ws_d      = do_wr ? ECTQ_BUS_ANSWER :
                      ((ws_q == ECTQ_BUS_ANSWER) & s_axi_bready) ? ECTQ_BUS_IDLE : ws_q;
   assign rs_d      = ar_hs ? ECTQ_BUS_ANSWER :
                      ((rs_q == ECTQ_BUS_ANSWER) & s_axi_rready) ? ECTQ_BUS_IDLE : rs_q;
   assign aw_have_d = do_wr ? 1'b0 : (aw_have_q | aw_hs);
   assign w_have_d  = do_wr ? 1'b0 : (w_have_q | w_hs);

   // Pin driver: the pin is an input in two-phase or direction-from-pin use, else a toggle when enabled.
   wire pin_drive = event_mode & pulse_en & ~two_phase & ~dir_pin;

   // Write channel: address and data are taken in either order, then answered together.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ws_q      <= ECTQ_BUS_IDLE;
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= `ECTQ_RST_BYTE;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `ECTQ_RESP_OKAY;
      end else if (clk_en) begin
         ws_q      <= ws_d;
         aw_have_q <= aw_have_d;
         w_have_q  <= w_have_d;
         awready_q <= (ws_d == ECTQ_BUS_IDLE) & ~aw_have_d;
         wready_q  <= (ws_d == ECTQ_BUS_IDLE) & ~w_have_d;
         if (aw_hs) begin
            awaddr_q <= s_axi_awaddr;
         end
         if (w_hs) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_bad ? `ECTQ_RESP_SLVERR : `ECTQ_RESP_OKAY;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Read channel: one cycle from the address handshake to valid data.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rs_q      <= ECTQ_BUS_IDLE;
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rresp_q   <= `ECTQ_RESP_OKAY;
         rdata_q   <= 32'h00000000;
      end else if (clk_en) begin
         rs_q      <= rs_d;
         arready_q <= (rs_d == ECTQ_BUS_IDLE);
         if (ar_hs) begin
            rvalid_q <= 1'b1;
            rresp_q  <= rd_bad ? `ECTQ_RESP_SLVERR : `ECTQ_RESP_OKAY;
            rdata_q  <= rd_bad ? 32'h00000000 : rd_word;
         end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // Mode and control registers.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         mode_q <= `ECTQ_RST_BYTE;
         ctrl_q <= `ECTQ_RST_BYTE;
      end else if (clk_en) begin
         if (wr_mode & wstrb_q[0]) begin
            mode_q <= wdata_q[7:0];
         end
         if (wr_ctrl & wstrb_q[0]) begin
            ctrl_q <= wdata_q[7:0];
         end
      end
   end

   // Counter and reload register. A write is judged against the start flag as it stood
   // before this cycle, so the counter is never loaded and stepped in one edge.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q    <= `ECTQ_RST_CNT;
         reload_q <= `ECTQ_RST_CNT;
      end else if (clk_en) begin
         if (wr_timer) begin
            reload_q <= wr_val16;
         end
         if (wr_timer & ~running) begin
            cnt_q <= wr_val16;
         end else if (step) begin
            cnt_q <= cnt_step;
         end
      end
   end

   // Edge history, interrupt pulse and output pin.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         in_prev_q <= 1'b0;
         ph_prev_q <= 1'b0;
         irq_q     <= 1'b0;
         toggle_q  <= 1'b0;
         pin_oe_q  <= 1'b0;
         last_up_q <= 1'b0;
      end else if (clk_en) begin
         in_prev_q <= in_lvl;
         ph_prev_q <= ph_lvl;
         irq_q     <= wrap;
         pin_oe_q  <= pin_drive;
         if (wrap & pulse_en & ~two_phase) begin
            toggle_q <= ~toggle_q;
         end
         if (step) begin
            last_up_q <= up;
         end
      end
   end

   // Software must rewrite the timer after stopping a free-run count; the block does not do it.

   assign s_axi_awready          = awready_q;
   assign s_axi_wready           = wready_q;
   assign s_axi_bvalid           = bvalid_q;
   assign s_axi_bresp            = bresp_q;
   assign s_axi_arready          = arready_q;
   assign s_axi_rvalid           = rvalid_q;
   assign s_axi_rresp            = rresp_q;
   assign s_axi_rdata            = rdata_q;
   assign toggle_or_phase_pin_o  = toggle_q;
   assign toggle_or_phase_pin_oe = pin_oe_q;
   assign irq_request            = irq_q;

endmodule // ectq_top

// ---- tb/ectq_top_asserts.sv ----
/* Concurrent checks on the bus handshakes, the interrupt pulse and the toggle output.
   Assumes binding to ectq_top, one clock domain and the active-high reset. */
`timescale 1ns/100ps

module ectq_top_asserts (
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready,
   input wire logic       toggle_or_phase_pin_o,
   input wire logic       toggle_or_phase_pin_oe,
   input wire logic       irq_request
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read data dropped early");
   a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   a_w_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid)
      else $error("write answer late");
   a_irq_single: assert property (irq_request |=> !irq_request)
      else $error("interrupt pulse too long");
   a_toggle_wrap: assert property (irq_request && toggle_or_phase_pin_oe && $past(toggle_or_phase_pin_oe)
      |-> toggle_or_phase_pin_o != $past(toggle_or_phase_pin_o))
      else $error("toggle did not invert on wrap");
endmodule // ectq_top_asserts

bind ectq_top ectq_top_asserts u_ectq_top_asserts (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .toggle_or_phase_pin_o(toggle_or_phase_pin_o),
   .toggle_or_phase_pin_oe(toggle_or_phase_pin_oe), .irq_request(irq_request));

// ---- tb/ectq_src_model.sv ----
/* Pulse source and two-phase encoder driving the count pins.
   Assumes the caller waits for each task; every level is held eight cycles so the synchroniser sees it. */
`timescale 1ns/100ps

module ectq_src_model (
   input  wire logic clk_sys,
   output logic      pin_a,
   output logic      pin_b
);
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
   end
   task automatic set_a(input logic v);
      @(posedge clk_sys);
      pin_a <= v;
      repeat (8) @(posedge clk_sys);
   endtask
   task automatic set_b(input logic v);
      @(posedge clk_sys);
      pin_b <= v;
      repeat (8) @(posedge clk_sys);
   endtask
   task automatic pulse();
      set_a(1'b1);
      set_a(1'b0);
   endtask
   // Forward order is 01, 11, 10, 00 in (a, b); only one pin moves per step.
   task automatic step(input logic up);
      if ((pin_a ^ pin_b) == up) set_a(!pin_a);
      else set_b(!pin_b);
   endtask
endmodule // ectq_src_model

// ---- tb/tb_event_counter_timer_two_phase.sv ----
/* Self-checking bench for one event counter channel on channel index 3.
   Assumes the AXI4-Lite slave timing of ectq_top and the pin model in ectq_src_model. */
`timescale 1ns/100ps

module tb_event_counter_timer_two_phase;
   logic clk_sys = 1'b0, sys_rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, cmp_ov = 1'b0, sib_ov = 1'b0, ce = 1'b1;
   logic [3:0] wstrb = 4'hF;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0] bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, pin_o, pin_oe, irq, src_a, src_b, phase_in;
   int fails = 0, comparisons = 0, irqs = 0;

   // The phase pin carries the channel's own output only while it drives.
   assign phase_in = pin_oe ? pin_o : src_b;

   ectq_top #(.CHANNEL_INDEX(3)) u_ectq_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(ce),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .event_input_pin(src_a), .toggle_or_phase_pin_i(phase_in),
      .toggle_or_phase_pin_o(pin_o), .toggle_or_phase_pin_oe(pin_oe),
      .companion_timer_overflow(cmp_ov), .sibling_channel_overflow(sib_ov), .irq_request(irq));
   ectq_src_model u_ectq_src_model (.clk_sys(clk_sys), .pin_a(src_a), .pin_b(src_b));

   initial begin
      forever #20 clk_sys = !clk_sys;
   end
   always @(posedge clk_sys) begin
      if (irq === 1'b1) irqs <= irqs + 1;
   end

   task automatic final_report();
      if (fails == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic tmo();
      fails++;
      $display("[ERR] %0t bus wait ran out", $time);
      final_report();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (n == 50) tmo();
      chk({30'h0, bresp}, {30'h0, er});
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_sys);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      if (n == 50) tmo();
      chk(rdata, e);
      chk({30'h0, rresp}, {30'h0, er});
   endtask
   task automatic tick(input int k, input logic s);
      repeat (k) begin
         @(posedge clk_sys);
         cmp_ov <= !s;
         sib_ov <= s;
         @(posedge clk_sys);
         cmp_ov <= 1'b0;
         sib_ov <= 1'b0;
         repeat (2) @(posedge clk_sys);
      end
   endtask

   initial begin
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rdc(8'h00, 32'h0, 2'h0);
      wr(8'h40, 32'h1, 2'h2);
      rdc(8'h40, 32'h0, 2'h2);
      wr(8'h00, 32'h3, 2'h0);
      wstrb <= 4'h2;
      wr(8'h00, 32'hAB00, 2'h0);
      rdc(8'h00, 32'hAB03, 2'h0);
      wr(8'h00, 32'h0, 2'h0);
      wstrb <= 4'hF;
      rdc(8'h00, 32'h3, 2'h0);
      wr(8'h04, 32'h01, 2'h0);
      wr(8'h08, 32'h09, 2'h0);
      // A pulse that arrives while the clock enable is low must be lost.
      ce <= 1'b0;
      tick(1, 1'b0);
      ce <= 1'b1;
      tick(3, 1'b0);
      rdc(8'h00, 32'h0, 2'h0);
      wr(8'h00, 32'h5, 2'h0);
      rdc(8'h00, 32'h0, 2'h0);
      // The read address is taken on the very edge of the underflow.
      fork
         tick(1, 1'b0);
         rdc(8'h00, 32'hFFFF, 2'h0);
      join
      rdc(8'h00, 32'h5, 2'h0);
      chk(irqs, 1);
      wr(8'h08, 32'h08, 2'h0);
      tick(2, 1'b0);
      rdc(8'h00, 32'h5, 2'h0);
      wr(8'h00, 32'hFFFE, 2'h0);
      wr(8'h04, 32'h45, 2'h0);
      wr(8'h08, 32'h13, 2'h0);
      tick(1, 1'b1);
      rdc(8'h00, 32'hFFFF, 2'h0);
      fork
         tick(1, 1'b1);
         rdc(8'h00, 32'h0, 2'h0);
      join
      rdc(8'h00, 32'h0, 2'h0);
      chk(irqs, 2);
      chk(pin_o, 1'b1);
      chk(pin_oe, 1'b1);
      rdc(8'h0C, 32'hE, 2'h0);
      wr(8'h08, 32'h02, 2'h0);
      wr(8'h00, 32'h0, 2'h0);
      wr(8'h04, 32'h09, 2'h0);
      wr(8'h08, 32'h03, 2'h0);
      u_ectq_src_model.pulse();
      u_ectq_src_model.pulse();
      rdc(8'h00, 32'h2, 2'h0);
      wr(8'h04, 32'h01, 2'h0);
      u_ectq_src_model.pulse();
      rdc(8'h00, 32'h3, 2'h0);
      wr(8'h04, 32'h1D, 2'h0);
      wr(8'h08, 32'h01, 2'h0);
      u_ectq_src_model.set_b(1'b1);
      u_ectq_src_model.pulse();
      rdc(8'h00, 32'h4, 2'h0);
      chk(pin_oe, 1'b0);
      u_ectq_src_model.set_b(1'b0);
      u_ectq_src_model.pulse();
      rdc(8'h00, 32'h3, 2'h0);
      wr(8'h08, 32'h00, 2'h0);
      wr(8'h00, 32'h0, 2'h0);
      wr(8'h04, 32'h01, 2'h0);
      wr(8'h08, 32'h05, 2'h0);
      repeat (8) u_ectq_src_model.step(1'b1);
      rdc(8'h00, 32'h2, 2'h0);
      repeat (4) u_ectq_src_model.step(1'b0);
      rdc(8'h00, 32'h1, 2'h0);
      wr(8'h04, 32'h81, 2'h0);
      wr(8'h00, 32'h7, 2'h0);
      repeat (3) u_ectq_src_model.step(1'b1);
      rdc(8'h00, 32'h4, 2'h0);
      repeat (5) u_ectq_src_model.step(1'b0);
      rdc(8'h00, 32'h7, 2'h0);
      chk(irqs, 3);
      final_report();
   end
endmodule // tb_event_counter_timer_two_phase
